// >>> logic/lsirp_alarm_engine.sv
`timescale 1ns/10ps
`include "lsirp_defs.svh"
module lsirp_alarm_engine
  import lsirp_pkg::*;
#(
  parameter int unsigned FULL_CYCLES = `LSIRP_CYC_W16
) (
  input  wire logic        mclk,       // System clock
  input  wire logic        resetn,     // Async reset, low
  input  wire logic [15:0] adc_sample, // Converter output
  lsirp_eng_if.eng         eif         // Settings and results
);

  logic [31:0] cnt_reg;
  logic [4:0]  pcnt_reg;
  logic        flag_reg;
  logic [15:0] reading_reg;
  logic [15:0] timer_reg;

  // Decode of settings
  wire         run     = eif.cmd[`LSIRP_CMD_EN] & ~eif.cmd[`LSIRP_CMD_PD];
  wire         ext     = eif.cmd[`LSIRP_CMD_TM];
  wire [31:0]  lim     = (eif.cmd[1:0] == 2'h0) ? FULL_CYCLES :
                         (eif.cmd[1:0] == 2'h1) ? `LSIRP_CYC_W12 :
                         (eif.cmd[1:0] == 2'h2) ? `LSIRP_CYC_W8 : `LSIRP_CYC_W4;
  wire [4:0]   need    = (eif.ctrl[1:0] == 2'h0) ? `LSIRP_PER_1 :
                         (eif.ctrl[1:0] == 2'h1) ? `LSIRP_PER_4 :
                         (eif.ctrl[1:0] == 2'h2) ? `LSIRP_PER_8 : `LSIRP_PER_16;
  // Internal timing ends on the count, external on the restart command
  // Compare with >= so a shorter width written mid-count still ends at once
  wire         int_end = ~ext & (cnt_reg >= lim - 32'h1);
  wire         ext_end = ext & eif.restart;
  wire         integ_end = run & (int_end | ext_end);
  wire         mode_ok = (eif.cmd[3:2] != 2'h3);
  // Threshold bytes are upper halves with a zero low byte
  wire [15:0]  thr_up  = {eif.thr_hi, `LSIRP_THR_LSB};
  wire [15:0]  thr_dn  = {eif.thr_lo, `LSIRP_THR_LSB};
  wire         outside = (adc_sample > thr_up) | (adc_sample < thr_dn);
  wire [4:0]   pcnt_inc = pcnt_reg + 5'h01;
  wire         set_flag = integ_end & mode_ok & outside & (pcnt_inc >= need);
  wire [15:0]  cnt_lo  = cnt_reg[15:0];

  // Integration counter; held cleared while the core is off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) cnt_reg <= 32'h0;
    else if (!run || integ_end) cnt_reg <= 32'h0;
    else cnt_reg <= cnt_reg + 32'h1;
  end

  // Result capture at each integration end, except when diode mode (cmd[3:2]) is 3
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reading_reg <= 16'h0000;
      timer_reg   <= 16'h0000;
    end else if (integ_end && mode_ok) begin
      reading_reg <= adc_sample;
      timer_reg   <= cnt_lo;
    end
  end

  // Consecutive out-of-window count, saturating at the target
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pcnt_reg <= 5'h00;
    else if (!run) pcnt_reg <= 5'h00;
    else if (integ_end && mode_ok) pcnt_reg <= outside ? ((pcnt_reg >= need) ? need : pcnt_inc)
                                                       : 5'h00;
  end

  // Sticky flag: a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) flag_reg <= 1'b0;
    else if (set_flag) flag_reg <= 1'b1;
    else if (eif.clear) flag_reg <= 1'b0;
  end

  assign eif.flag    = flag_reg;
  assign eif.reading = reading_reg;
  assign eif.timer   = timer_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_FLAG_SET: assert property (set_flag |=> flag_reg)
    else $error("flag not set after persistence met");
  AST_FLAG_CAUSE: assert property ($rose(flag_reg) |-> $past(set_flag))
    else $error("flag rose without a qualifying conversion");
  AST_READING: assert property (integ_end && mode_ok |=> reading_reg == $past(adc_sample))
    else $error("reading not captured at integration end");
  AST_TIMER: assert property (integ_end && mode_ok |=> timer_reg == $past(cnt_lo))
    else $error("timer count not captured at integration end");
  AST_WIDTH: assert property (run && !ext && $stable(eif.cmd) |-> cnt_reg < lim)
    else $error("integration ran past its cycle count");
  COV_FLAG: cover property (set_flag);
  COV_EXT_END: cover property (ext_end && run);

endmodule : lsirp_alarm_engine

// >>> logic/lsirp_defs.svh
`ifndef LSIRP_DEFS_SVH
`define LSIRP_DEFS_SVH

// Fixed bus address of the port
`define LSIRP_SLV_ADDR    7'h44

// Register offsets
`define LSIRP_OFF_CMD     3'h0
`define LSIRP_OFF_CTRL    3'h1
`define LSIRP_OFF_THR_HI  3'h2
`define LSIRP_OFF_THR_LO  3'h3
`define LSIRP_OFF_RD_LO   3'h4
`define LSIRP_OFF_RD_HI   3'h5
`define LSIRP_OFF_TMR_LO  3'h6
`define LSIRP_OFF_TMR_HI  3'h7

// Field positions
`define LSIRP_CMD_EN      7
`define LSIRP_CMD_PD      6
`define LSIRP_CMD_TM      5
`define LSIRP_CTRL_FLAG   5
`define LSIRP_AB_RESTART  7
`define LSIRP_AB_CLEAR    6

// Reset values and the fixed threshold low byte
`define LSIRP_RST_CMD     8'h00
`define LSIRP_RST_CTRL    4'h0
`define LSIRP_RST_THR_HI  8'hff
`define LSIRP_RST_THR_LO  8'h00
`define LSIRP_THR_LSB     8'h00

// Cycles per conversion and persistence counts
`define LSIRP_CYC_W16     65536
`define LSIRP_CYC_W12     32'h0000_1000
`define LSIRP_CYC_W8      32'h0000_0100
`define LSIRP_CYC_W4      32'h0000_0010
`define LSIRP_PER_1       5'h01
`define LSIRP_PER_4       5'h04
`define LSIRP_PER_8       5'h08
`define LSIRP_PER_16      5'h10

`endif

// >>> logic/lsirp_eng_if.sv
`timescale 1ns/10ps
// Settings and results between register port and alarm engine
interface lsirp_eng_if;
  logic [7:0]  cmd;
  logic [3:0]  ctrl;
  logic [7:0]  thr_hi;
  logic [7:0]  thr_lo;
  logic        restart;
  logic        clear;
  logic        flag;
  logic [15:0] reading;
  logic [15:0] timer;

  modport regs (output cmd, ctrl, thr_hi, thr_lo, restart, clear,
                input  flag, reading, timer);
  modport eng  (input  cmd, ctrl, thr_hi, thr_lo, restart, clear,
                output flag, reading, timer);
endinterface : lsirp_eng_if

// >>> logic/lsirp_pkg.sv
package lsirp_pkg;

  // Link state of the bus slave
  typedef enum logic [3:0] {
    LSIRP_IDLE      = 4'h0,
    LSIRP_ADDR      = 4'h1,
    LSIRP_ADDR_ACK  = 4'h2,
    LSIRP_REG       = 4'h3,
    LSIRP_REG_ACK   = 4'h4,
    LSIRP_WDATA     = 4'h5,
    LSIRP_WDATA_ACK = 4'h6,
    LSIRP_RDATA     = 4'h7,
    LSIRP_RACK      = 4'h8
  } lsirp_state_t;

endpackage : lsirp_pkg

// >>> logic/lsirp_port.sv
`timescale 1ns/10ps
`include "lsirp_defs.svh"
module lsirp_port
  import lsirp_pkg::*;
#(
  parameter int unsigned FULL_CYCLES = `LSIRP_CYC_W16 // Longest conversion, cycles
) (
  input  wire logic        mclk,                 // System clock, 250 MHz
  input  wire logic        resetn,               // Async reset, low
  input  wire logic        scl_in,               // Bus clock pin
  input  wire logic        sda_in,               // Bus data pin, input side
  output logic             sda_out,              // Bus data drive level
  output logic             sda_oe_n,             // Bus data enable, low drives
  output logic             int_out,              // Alarm pin drive level
  output logic             int_oe_n,             // Alarm enable, low pulls pin
  input  wire logic [15:0] adc_sample,           // Converter result
  output logic             conv_enable,          // Converter core enabled
  output logic             converter_power_down, // Device powered down
  output logic             ext_timing,           // Host-timed integration
  output logic [1:0]       diode_mode,           // Photodiode selection
  output logic [1:0]       gain_range            // Gain range select
);

  lsirp_eng_if eif ();

  lsirp_state_t state_reg;
  logic [2:0]   scl_sync_reg;
  logic [2:0]   sda_sync_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   tx_reg;
  logic [2:0]   ptr_reg;
  logic         rw_reg;
  logic         nack_reg;
  logic         sda_oe_n_reg;
  logic         int_oe_n_reg;
  logic [7:0]   cmd_reg;
  logic [3:0]   ctrl_reg;
  logic [7:0]   thr_hi_reg;
  logic [7:0]   thr_lo_reg;
  logic         restart_reg;
  logic         clear_reg;

  // Two-flop synchronisers; stage 3 is only the edge history
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  // Line events, read from synchronised stages only
  wire scl_now   = scl_sync_reg[1];
  wire scl_prev  = scl_sync_reg[2];
  wire sda_now   = sda_sync_reg[1];
  wire sda_prev  = sda_sync_reg[2];
  wire scl_rise  = scl_now & ~scl_prev;
  wire scl_fall  = ~scl_now & scl_prev;
  wire start_det = scl_now & scl_prev & sda_prev & ~sda_now;
  wire stop_det  = scl_now & scl_prev & ~sda_prev & sda_now;
  wire byte_full = (bit_cnt_reg == 4'h8);

  // Byte completion strobes
  wire addr_done = scl_fall & (state_reg == LSIRP_ADDR) & byte_full;
  wire addr_hit  = (shift_reg[7:1] == `LSIRP_SLV_ADDR);
  wire reg_done  = scl_fall & (state_reg == LSIRP_REG) & byte_full;
  wire wr_strobe = scl_fall & (state_reg == LSIRP_WDATA) & byte_full;
  wire wr_cmd    = wr_strobe & (ptr_reg == `LSIRP_OFF_CMD);
  wire wr_ctrl   = wr_strobe & (ptr_reg == `LSIRP_OFF_CTRL);
  wire wr_hi     = wr_strobe & (ptr_reg == `LSIRP_OFF_THR_HI);
  wire wr_lo     = wr_strobe & (ptr_reg == `LSIRP_OFF_THR_LO);

  // Address byte command bits, plus the clear from a control write with the flag bit low
  wire restart_next = reg_done & shift_reg[`LSIRP_AB_RESTART]
                      & cmd_reg[`LSIRP_CMD_TM];
  wire clear_next   = (reg_done & shift_reg[`LSIRP_AB_CLEAR])
                      | (wr_ctrl & ~shift_reg[`LSIRP_CTRL_FLAG]);

  // Read map; reserved control bits read zero
  wire [7:0] ctrl_rd = {2'b00, eif.flag, 1'b0, ctrl_reg};
  wire [7:0] rd_map [8];
  assign rd_map[0] = cmd_reg & 8'hef;
  assign rd_map[1] = ctrl_rd;
  assign rd_map[2] = thr_hi_reg;
  assign rd_map[3] = thr_lo_reg;
  assign rd_map[4] = eif.reading[7:0];
  assign rd_map[5] = eif.reading[15:8];
  assign rd_map[6] = eif.timer[7:0];
  assign rd_map[7] = eif.timer[15:8];
  wire [7:0] rd_byte = rd_map[ptr_reg];

  // Bus slave sequence; data changes only after a clock fall
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= LSIRP_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'hff;
      ptr_reg      <= 3'h0;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else if (start_det) begin
      state_reg    <= LSIRP_ADDR;
      bit_cnt_reg  <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg    <= LSIRP_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else if (scl_rise) begin
      case (state_reg)
        LSIRP_ADDR, LSIRP_REG, LSIRP_WDATA: begin
          shift_reg   <= {shift_reg[6:0], sda_now};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        LSIRP_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
        LSIRP_RACK:  nack_reg    <= sda_now;
        default:     nack_reg    <= nack_reg;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        LSIRP_ADDR: begin
          if (byte_full && addr_hit) begin
            rw_reg       <= shift_reg[0];
            sda_oe_n_reg <= 1'b0;
            state_reg    <= LSIRP_ADDR_ACK;
          end else if (byte_full) begin
            state_reg    <= LSIRP_IDLE;
          end
        end
        LSIRP_ADDR_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (rw_reg) begin
            tx_reg       <= rd_byte;
            sda_oe_n_reg <= rd_byte[7];
            state_reg    <= LSIRP_RDATA;
          end else begin
            sda_oe_n_reg <= 1'b1;
            state_reg    <= LSIRP_REG;
          end
        end
        LSIRP_REG: begin
          if (byte_full) begin
            ptr_reg      <= shift_reg[2:0];
            sda_oe_n_reg <= 1'b0;
            state_reg    <= LSIRP_REG_ACK;
          end
        end
        LSIRP_WDATA: begin
          if (byte_full) begin
            sda_oe_n_reg <= 1'b0;
            state_reg    <= LSIRP_WDATA_ACK;
          end
        end
        LSIRP_REG_ACK, LSIRP_WDATA_ACK: begin
          sda_oe_n_reg <= 1'b1;
          bit_cnt_reg  <= 4'h0;
          state_reg    <= LSIRP_WDATA;
        end
        LSIRP_RDATA: begin
          if (byte_full) begin
            sda_oe_n_reg <= 1'b1; // Master acknowledges
            ptr_reg      <= ptr_reg + 3'h1;
            state_reg    <= LSIRP_RACK;
          end else begin
            tx_reg       <= {tx_reg[6:0], 1'b1};
            sda_oe_n_reg <= tx_reg[6];
          end
        end
        LSIRP_RACK: begin
          bit_cnt_reg <= 4'h0;
          if (nack_reg) begin
            state_reg <= LSIRP_IDLE;
          end else begin
            tx_reg       <= rd_byte;
            sda_oe_n_reg <= rd_byte[7];
            state_reg    <= LSIRP_RDATA;
          end
        end
        default: state_reg <= LSIRP_IDLE;
      endcase
    end
  end

  // Configuration registers; only bus writes change them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg    <= `LSIRP_RST_CMD;
      ctrl_reg   <= `LSIRP_RST_CTRL;
      thr_hi_reg <= `LSIRP_RST_THR_HI;
      thr_lo_reg <= `LSIRP_RST_THR_LO;
    end else begin
      if (wr_cmd)  cmd_reg    <= shift_reg;
      if (wr_ctrl) ctrl_reg   <= shift_reg[3:0];
      if (wr_hi)   thr_hi_reg <= shift_reg;
      if (wr_lo)   thr_lo_reg <= shift_reg;
    end
  end

  // One-cycle command pulses and the alarm pin enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      restart_reg  <= 1'b0;
      clear_reg    <= 1'b0;
      int_oe_n_reg <= 1'b1;
    end else begin
      restart_reg  <= restart_next;
      clear_reg    <= clear_next;
      int_oe_n_reg <= ~eif.flag; // Pin pulled low while flag stands
    end
  end

  // Settings to the alarm engine
  assign eif.cmd     = cmd_reg;
  assign eif.ctrl    = ctrl_reg;
  assign eif.thr_hi  = thr_hi_reg;
  assign eif.thr_lo  = thr_lo_reg;
  assign eif.restart = restart_reg;
  assign eif.clear   = clear_reg;

  lsirp_alarm_engine #(
    .FULL_CYCLES (FULL_CYCLES)
  ) u_engine (
    .mclk       (mclk),
    .resetn     (resetn),
    .adc_sample (adc_sample),
    .eif        (eif.eng)
  );

  // Pins; open-drain lines only ever drive low
  assign sda_out              = 1'b0;
  assign int_out              = 1'b0;
  assign sda_oe_n             = sda_oe_n_reg;
  assign int_oe_n             = int_oe_n_reg;
  assign conv_enable          = cmd_reg[`LSIRP_CMD_EN];
  assign converter_power_down = cmd_reg[`LSIRP_CMD_PD];
  assign ext_timing           = cmd_reg[`LSIRP_CMD_TM];
  assign diode_mode           = cmd_reg[3:2];
  assign gain_range           = ctrl_reg[3:2];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_ADDR_ACK: assert property (addr_done && addr_hit |=> !sda_oe_n_reg)
    else $error("matching address not acknowledged");
  AST_ADDR_MISS: assert property (addr_done && !addr_hit |=> state_reg == LSIRP_IDLE
                                  && sda_oe_n_reg)
    else $error("foreign address not ignored");
  AST_ACK_RELEASE: assert property (wr_strobe ##1 !sda_oe_n_reg [*1] ##0 (!scl_fall && !stop_det
                                    && !start_det) [*1] |=> !sda_oe_n_reg)
    else $error("write acknowledge dropped early");
  AST_CMD_HOLD: assert property (!wr_cmd |=> $stable(cmd_reg))
    else $error("command register changed without a write");
  AST_CTRL_HOLD: assert property (!wr_ctrl |=> $stable(ctrl_reg))
    else $error("control register changed without a write");
  AST_STOP_FREE: assert property (stop_det |=> sda_oe_n_reg && state_reg == LSIRP_IDLE)
    else $error("data line held after stop");
  AST_CLEAR: assert property (reg_done && shift_reg[6] |=> clear_reg
                              ##1 (!eif.flag || $past(u_engine.set_flag)))
    else $error("clear command not issued");
  AST_RESTART_INT: assert property (reg_done && !cmd_reg[5] |=> !restart_reg)
    else $error("restart issued in internal timing");
  AST_CTRL_RSVD: assert property (wr_ctrl |=> ctrl_rd[7:6] == 2'b00 && ctrl_rd[4] == 1'b0
                                  && ctrl_reg == $past(shift_reg[3:0]))
    else $error("reserved control bits read nonzero");
  AST_ALARM_PIN: assert property ($rose(eif.flag) |=> !int_oe_n_reg)
    else $error("alarm pin not pulled after flag set");
  COV_WRITE: cover property (wr_strobe);
  COV_READ: cover property (state_reg == LSIRP_RDATA && scl_fall && byte_full);
  COV_RESTART: cover property (restart_reg);

endmodule : lsirp_port

// >>> sim/light_sensor_i2c_register_port_tb_top.sv
`timescale 1ns/10ps
module light_sensor_i2c_register_port_tb_top;
  logic        mclk = 1'b0;
  logic        resetn;
  logic [15:0] adc_sample;
  logic        scl, sda_rel, sda_out, sda_oe_n, int_out, int_oe_n, ok;
  logic        conv_enable, converter_power_down, ext_timing;
  logic [1:0]  diode_mode, gain_range;
  logic [31:0] rng;
  logic [63:0] rd_data;
  int          fails = 0, n_compared = 0, cycles = 0, m_flag = 0;
  int          m_reg [8];
  // Both lines are open drain with pull-ups
  wire         sda_line = sda_rel & (sda_oe_n ? 1'b1 : sda_out);
  wire         int_line = int_oe_n ? 1'b1 : int_out;

  lsirp_port #(.FULL_CYCLES(64)) dut (
    .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .adc_sample(adc_sample), .conv_enable(conv_enable),
    .converter_power_down(converter_power_down), .ext_timing(ext_timing),
    .diode_mode(diode_mode), .gain_range(gain_range));
  lsirp_mst mst (.sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  always #2 mclk = ~mclk;

  // Some 35 bus frames of about 1000 cycles each; generous ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails++;
      results();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // New converter value; model assumes it is captured at the next integration end
  task automatic feed(input logic [15:0] v);
    @(posedge mclk);
    adc_sample <= v;
    m_reg[4] = v[7:0];
    m_reg[5] = v[15:8];
  endtask : feed

  // Register write mirrored in the model; unstored bits read back zero
  task automatic mwr(input logic [7:0] ptr, input logic [7:0] d);
    mst.wr(8'h88, ptr, d, ok);
    check("write ack", ok, 1'b1);
    case (ptr[2:0])
      3'h0: m_reg[0] = d & 8'hef;
      3'h1: m_reg[1] = d & 8'h0f;
      3'h2, 3'h3: m_reg[ptr[2:0]] = d;
      default: ;
    endcase
    if (ptr[6] || (ptr[2:0] == 3'h1 && !d[5])) begin
      m_flag = 0;
    end
  endtask : mwr

  task automatic mrd(input logic [7:0] ptr, input int n);
    int k;
    mst.rd(ptr, n, rd_data, ok);
    check("read ack", ok, 1'b1);
    for (int i = 0; i < n; i++) begin
      k = (ptr + i) % 8;
      check($sformatf("reg %0d", k), rd_data[8*i +: 8],
            (k == 1) ? (m_reg[1] | (m_flag << 5)) : m_reg[k]);
    end
  endtask : mrd

  task automatic pin(input logic exp);
    check("alarm pin", int_line, exp);
  endtask : pin

  initial begin
    resetn     = 1'b0;
    adc_sample = 16'h0000;
    rng        = 32'h69e5b8fb;
    m_reg      = '{0, 0, 8'hff, 0, 0, 0, 0, 0};
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    idle(4);
    // Writes to the read-only bytes must not stick
    mwr(8'h05, 8'h5a);
    mwr(8'h07, 8'ha5);
    mrd(8'h00, 8);
    check("enable", conv_enable, 1'b0);
    $display("test reset_values done");
    // Foreign addresses stay unanswered
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      mst.wr({(rng[6:0] == 7'h44) ? 7'h45 : rng[6:0], 1'b0}, 8'h00, 8'h00, ok);
      check("foreign ack", ok, 1'b0);
    end
    $display("test foreign_address done");
    // Every mode, width and gain code, random other bits
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      feed({1'b0, rng[30:16]});
      mwr(8'h00, {rng[7:4], i[1:0], i[1:0]});
      mwr(8'h01, {4'h0, i[1:0], rng[9:8]});
      check("enable", conv_enable, m_reg[0][7]);
      check("power down", converter_power_down, m_reg[0][6]);
      check("ext timing", ext_timing, m_reg[0][5]);
      check("diode mode", diode_mode, m_reg[0][3:2]);
      check("gain", gain_range, m_reg[1][3:2]);
      mrd(8'h00, 2);
    end
    $display("test settings done");
    // Window 0x1000..0x4000 inclusive, persistence of one
    // In-window sample first, so narrowing the window cannot fire early
    feed(16'h2000);
    mwr(8'h00, 8'h80);
    mwr(8'h01, 8'h00);
    mwr(8'h02, 8'h40);
    mwr(8'h03, 8'h10);
    feed(16'h4000);
    idle(150);
    pin(1'b1);
    feed(16'h1000);
    idle(150);
    pin(1'b1);
    mrd(8'h02, 4);
    feed(16'h0fff);
    idle(150);
    m_flag = 1;
    pin(1'b0);
    mrd(8'h01, 1);
    feed(16'h2000);
    idle(150);
    mwr(8'h42, 8'h40);
    pin(1'b1);
    mrd(8'h01, 1);
    feed(16'h4001);
    idle(150);
    m_flag = 1;
    pin(1'b0);
    feed(16'h2000);
    idle(150);
    mwr(8'h01, 8'h01);
    pin(1'b1);
    mrd(8'h01, 1);
    // Persistence of four: silent after two conversions, firing within the next 400 cycles
    feed(16'h4001);
    idle(120);
    pin(1'b1);
    for (int k = 0; k < 400 && int_line; k++) begin
      @(posedge mclk);
    end
    m_flag = 1;
    pin(1'b0);
    feed(16'h2000);
    idle(150);
    mwr(8'h40, 8'h80);
    $display("test alarm done");
    // Host-timed integration, two restarts one write frame apart
    mwr(8'h00, 8'ha0);
    feed(16'h1234);
    mwr(8'h80, 8'ha0);
    feed(16'h2345);
    mwr(8'h80, 8'ha0);
    mrd(8'h04, 2);
    mst.rd(8'h06, 2, rd_data, ok);
    check("timer ack", ok, 1'b1);
    // One frame is about 899 cycles; allow synchroniser jitter
    check("timer", rd_data[15:0] >= 16'h037e && rd_data[15:0] <= 16'h0387, 1'b1);
    $display("test external_timing done");
    results();
  end
endmodule : light_sensor_i2c_register_port_tb_top

// >>> sim/lsirp_mst.sv
`timescale 1ns/10ps
// Bus master stand-in; its clock only moves inside frames, 125 ns per bit
module lsirp_mst (
  input  wire logic sda_line, // Resolved data line
  output logic      scl,      // Bus clock
  output logic      sda_rel   // High lets the pull-up win
);
  localparam real QTR = 31.25;

  // Idle bus: both lines high
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // One bit: data set while the clock is low, sampled mid-high
  task automatic bit_io(input logic rel, output logic seen);
    sda_rel = rel;
    #QTR;
    scl = 1'b1;
    #QTR;
    seen = sda_line;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask : bit_io

  // Data falls under a high clock; also serves as repeated start
  task automatic start();
    sda_rel = 1'b1;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_rel = 1'b0;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask : start

  // Data rises under a high clock
  task automatic stop();
    sda_rel = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_rel = 1'b1;
    #QTR;
  endtask : stop

  // Byte out, MSB first, then the receiver's acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send

  // Device byte, pointer byte, one data byte
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                    output logic ok);
    logic a0, a1, a2;
    start();
    send(dev, a0);
    send(ptr, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr

  // Pointer write, repeated start, n bytes; the last one refused
  task automatic rd(input logic [7:0] ptr, input int n, output logic [63:0] d,
                    output logic ok);
    logic a0, a1, a2, s;
    start();
    send(8'h88, a0);
    send(ptr, a1);
    start();
    send(8'h89, a2);
    d = '0;
    for (int i = 0; i < 8 * n; i++) begin
      bit_io(1'b1, s);
      d[8 * (i / 8) + 7 - i % 8] = s;
      if (i % 8 == 7) begin
        bit_io(i == 8 * n - 1, s);
      end
    end
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : lsirp_mst
